/* src/dshp_host_port.sv */
// device end of the dual style host bus port
`timescale 1ns/100ps
`default_nettype none

module dshp_host_port
  import dshp_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // host pins
  input wire logic bus_style,
  input wire logic cs_n,
  input wire logic combined_data_strobe,
  input wire logic rd_n,
  input wire logic [2:0] addr,
  input wire logic [15:0] data_in,
  output logic [15:0] data_out,
  output logic data_oe_n,
  output logic new_data_irq_n,
  // target register side
  output logic tgt_wr,
  output logic [1:0] tgt_addr,
  output logic [15:0] tgt_wdata,
  output logic [1:0] rd_addr,
  input wire logic [15:0] rd_data,
  // channel output side
  input wire logic [15:0] chan_data,
  input wire logic chan_synced,
  input wire logic new_data,
  input wire logic [7:0] irq_len
);

  // pin bundle through the synchronizer; it resets to the idle pin
  // levels so that no strobe edge is seen as reset ends

  logic [PIN_W-1:0] pins_s;
  logic style_s;
  logic cs_n_s;
  logic strobe_s;
  logic rd_s;
  logic [2:0] addr_s;
  logic [15:0] data_s;

  // data and address pass the same two stages as the strobe, so the
  // host must hold them steady around the strobe edge
  dshp_sync #(
    .WIDTH(PIN_W),
    .RST_VAL(PIN_RST)
  ) u_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .async_in({cs_n, combined_data_strobe, rd_n, bus_style, addr, data_in}),
    .sync_out(pins_s)
  );

  assign {cs_n_s, strobe_s, rd_s, style_s, addr_s, data_s} = pins_s;

  // strobe edge detection on the synchronized copy
  logic strobe_prev_q;
  logic cs_n_prev_q;
  logic strobe_rise;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      strobe_prev_q <= 1'b1;
      cs_n_prev_q <= 1'b1;
    end else begin
      strobe_prev_q <= strobe_s;
      cs_n_prev_q <= cs_n_s;
    end
  end

  // select is sampled as it stood while the strobe was low
  assign strobe_rise = strobe_s && !strobe_prev_q && !cs_n_prev_q;

  // bus style: the pin is pulled low outside, so an open pin gives
  // the separate-strobe style
  dshp_style_t style;
  assign style = style_s ? DSHP_DATA_STROBE : DSHP_SEP_STROBE;

  // only the two low address bits decode; the top bit is dropped here
  logic [1:0] dec_addr;
  assign dec_addr = addr_s[1:0];

  // cycle classification
  logic write_ev;
  logic read_act;

  always_comb begin
    write_ev = 1'b0;
    read_act = 1'b0;
    unique case (style)
      DSHP_SEP_STROBE: begin
        write_ev = strobe_rise;
        read_act = !cs_n_s && !rd_s;
      end
      DSHP_DATA_STROBE: begin
        // rd_n acts as the direction line here: high reads, low writes
        write_ev = strobe_rise && !rd_s;
        read_act = !cs_n_s && !strobe_s && rd_s;
      end
    endcase
  end

  // write holding register and target transfer
  logic [15:0] hold_q;
  logic tgt_wr_q;
  logic [1:0] tgt_addr_q;
  logic [15:0] tgt_wdata_q;
  logic [15:0] data_prev_q;
  logic [1:0] addr_prev_q;

  // data and address held one cycle so they match the strobe level
  // that preceded the detected rising edge
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      data_prev_q <= HOLD_RST;
      addr_prev_q <= ADDR_RST;
    end else begin
      data_prev_q <= data_s;
      addr_prev_q <= dec_addr;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      hold_q <= HOLD_RST;
    end else if (write_ev && addr_prev_q == ADDR_HOLD) begin
      hold_q <= data_prev_q;
    end
  end

  // a target write always carries the holding register, so a commit
  // without a fresh load repeats the last loaded word
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      tgt_wr_q <= 1'b0;
      tgt_addr_q <= ADDR_RST;
      tgt_wdata_q <= HOLD_RST;
    end else begin
      tgt_wr_q <= write_ev && addr_prev_q != ADDR_HOLD;
      if (write_ev && addr_prev_q != ADDR_HOLD) begin
        tgt_addr_q <= addr_prev_q;
        tgt_wdata_q <= hold_q;
      end
    end
  end

  assign tgt_wr = tgt_wr_q;
  assign tgt_addr = tgt_addr_q;
  assign tgt_wdata = tgt_wdata_q;

  // read path: address goes out registered, data is muxed and
  // registered before it reaches the pins
  // the drive enable trails the pins by three edges; a host that turns
  // its own drivers on sooner than that will briefly fight the port
  logic [1:0] rd_addr_q;
  logic [15:0] rd_mux;
  logic [15:0] dout_q;
  logic oe_n_q;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rd_addr_q <= ADDR_RST;
    end else begin
      rd_addr_q <= dec_addr;
    end
  end

  assign rd_addr = rd_addr_q;

  always_comb begin
    unique case (rd_addr_q)
      ADDR_HOLD: rd_mux = hold_q;
      // unsynchronized channels read as zero
      ADDR_CHAN: rd_mux = chan_synced ? chan_data : DOUT_RST;
      default: rd_mux = rd_data;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      dout_q <= DOUT_RST;
      oe_n_q <= 1'b1;
    end else begin
      dout_q <= rd_mux;
      oe_n_q <= !read_act;
    end
  end

  assign data_out = dout_q;
  assign data_oe_n = oe_n_q;

  // interrupt pulse: a new event restarts the count; a length of zero
  // still gives one cycle so no event goes unseen
  logic [7:0] irq_cnt_q;
  logic irq_n_q;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      irq_cnt_q <= IRQ_CNT_RST;
    end else if (new_data) begin
      irq_cnt_q <= (irq_len == IRQ_CNT_RST) ? IRQ_CNT_ONE : irq_len;
    end else if (irq_cnt_q != IRQ_CNT_RST) begin
      irq_cnt_q <= irq_cnt_q - IRQ_CNT_ONE;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      irq_n_q <= 1'b1;
    end else begin
      irq_n_q <= !(new_data || irq_cnt_q > IRQ_CNT_ONE);
    end
  end

  assign new_data_irq_n = irq_n_q;

endmodule : dshp_host_port

`default_nettype wire

/* src/dshp_pkg.sv */
// constants and types shared by the dual style host bus port
// Behaviour
// - separate-strobe style: write strobe rising with chip select low moves data
// - strobe style: write pin acts as combined data strobe, direction picks read/write
// - strobe style write: direction low, transfer on data strobe rising edge
// - strobe style read: direction high, drive addressed data while strobe low
// - separate-strobe style read: drive addressed data while read and select low
// - mode input picks bus style; undriven means separate-strobe style
// - address is three bits; only the two low bits decode, top ignored
// - sixteen-bit data bus, bit 15 most significant, driven only when reading
// - interrupt held for a programmable count of clocks per new data
// - channel output readable through the port only when channels synchronized
`default_nettype none

package dshp_pkg;

  localparam int DATA_W = 16;
  localparam int ADDR_W = 3;
  localparam int DEC_W = 2;
  localparam int IRQ_LEN_W = 8;
  localparam int SYNC_STAGES = 2;

  // decoded address slots of the low two address bits
  localparam logic [1:0] ADDR_HOLD = 2'h0;
  localparam logic [1:0] ADDR_CHAN = 2'h3;

  // reset values
  localparam logic [15:0] HOLD_RST = 16'h0000;
  localparam logic [15:0] DOUT_RST = 16'h0000;
  localparam logic [7:0] IRQ_CNT_RST = 8'h00;
  localparam logic [7:0] IRQ_CNT_ONE = 8'h01;
  localparam logic [1:0] ADDR_RST = 2'h0;
  // synchronizer reset: select, strobe and read line idle high, rest low
  localparam int PIN_W = 4 + ADDR_W + DATA_W;
  localparam logic [PIN_W-1:0] PIN_RST = {4'he, 19'h00000};

  // bus style selected by the mode pin
  typedef enum logic [1:0] {
    DSHP_SEP_STROBE = 2'b01,
    DSHP_DATA_STROBE = 2'b10
  } dshp_style_t;

endpackage : dshp_pkg

`default_nettype wire

/* src/dshp_sync.sv */
// two flip-flop synchronizer, one chain per bit
`timescale 1ns/100ps
`default_nettype none

module dshp_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // asynchronous in, synchronous out
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic meta_q;
      logic stable_q;
      // the first stage feeds only the second
      always_ff @(posedge mclk) begin
        if (!rst_n) begin
          meta_q <= RST_VAL[i];
          stable_q <= RST_VAL[i];
        end else begin
          meta_q <= async_in[i];
          stable_q <= meta_q;
        end
      end
      assign sync_out[i] = stable_q;
    end
  endgenerate

endmodule : dshp_sync

`default_nettype wire

/* bench/dshp_host_port_properties.sv */
// concurrent checks on the host port pins
`timescale 1ns/100ps
`default_nettype none
module dshp_chk (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // host pins
  input wire logic bus_style,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic combined_data_strobe,
  // port outputs
  input wire logic [15:0] data_out,
  input wire logic data_oe_n,
  input wire logic new_data_irq_n,
  input wire logic tgt_wr,
  input wire logic [1:0] tgt_addr,
  input wire logic [1:0] rd_addr,
  // channel side
  input wire logic chan_synced,
  input wire logic new_data,
  input wire logic [7:0] irq_len
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence s_rd0;
    !cs_n && !rd_n && !bus_style;
  endsequence
  sequence s_rd1;
    !cs_n && !combined_data_strobe && rd_n && bus_style;
  endsequence
  a_irq_start: assert property (new_data |=> !new_data_irq_n)
    else $error("irq late");
  a_irq_one: assert property (new_data && irq_len == 8'h01
    ##1 !new_data |=> new_data_irq_n) else $error("irq long");
  a_wr_pulse: assert property (tgt_wr |=> !tgt_wr)
    else $error("commit pulse long");
  a_wr_unsel: assert property (cs_n [*6] |-> !tgt_wr)
    else $error("commit without select");
  a_wr_addr: assert property (tgt_wr |-> tgt_addr != 2'h0)
    else $error("commit to holding slot");
  a_drive_sel: assert property (!data_oe_n |-> !$past(cs_n, 3))
    else $error("drive without select");
  a_rd_sep: assert property (s_rd0 [*5] |-> !data_oe_n)
    else $error("no drive on read");
  a_rd_strb: assert property (s_rd1 [*5] |-> !data_oe_n)
    else $error("no drive on strobe read");
  a_chan_zero: assert property (!data_oe_n && rd_addr == 2'h3
    && $stable(rd_addr) && !chan_synced && $stable(chan_synced)
    |-> data_out == 16'h0000) else $error("unsynced channel read");
endmodule : dshp_chk
bind dshp_host_port dshp_chk u_chk (
  .mclk(mclk),
  .rst_n(rst_n),
  .bus_style(bus_style),
  .cs_n(cs_n),
  .rd_n(rd_n),
  .combined_data_strobe(combined_data_strobe),
  .data_out(data_out),
  .data_oe_n(data_oe_n),
  .new_data_irq_n(new_data_irq_n),
  .tgt_wr(tgt_wr),
  .tgt_addr(tgt_addr),
  .rd_addr(rd_addr),
  .chan_synced(chan_synced),
  .new_data(new_data),
  .irq_len(irq_len)
);
`default_nettype wire

/* bench/dshp_host_model.sv */
// host processor model driving the port pins
`timescale 1ns/100ps
`default_nettype none
module dshp_host_model (
  // bus clock
  input wire logic mclk,
  // host pins
  output logic cs_n,
  output logic combined_data_strobe,
  output logic rd_n,
  output logic [2:0] addr,
  output logic [15:0] host_d,
  input wire logic [15:0] data_in
);
  initial begin
    cs_n = 1'b1;
    combined_data_strobe = 1'b1;
    rd_n = 1'b1;
    addr = 3'h0;
    host_d = 16'h0000;
  end
  // s style, w write, c select level; slow host, pins synced inside
  task automatic xfer(logic s, w, c, logic [2:0] a, logic [15:0] d,
      output logic [15:0] q);
    @(posedge mclk);
    cs_n <= c;
    addr <= a;
    host_d <= d;
    rd_n <= w ^ s;
    combined_data_strobe <= ~(w | s);
    repeat (6) @(posedge mclk);
    q = data_in;
    combined_data_strobe <= 1'b1;
    repeat (3) @(posedge mclk);
    cs_n <= 1'b1;
    rd_n <= 1'b1;
    host_d <= ~d;
    repeat (4) @(posedge mclk);
  endtask : xfer
endmodule : dshp_host_model
`default_nettype wire

/* bench/tb_dual_style_host_bus_port.sv */
// self-checking bench for the dual style host bus port
`timescale 1ns/100ps
`default_nettype none
module tb_dual_style_host_bus_port;
  logic mclk = 1'b0, rst_n = 1'b0, bus_style = 1'b0;
  logic chan_synced = 1'b0, new_data = 1'b0;
  logic cs_n, combined_data_strobe, rd_n, data_oe_n, new_data_irq_n;
  logic tgt_wr;
  logic [2:0] addr;
  logic [1:0] tgt_addr, rd_addr, a, wa;
  logic [7:0] irq_len = 8'h01;
  logic [15:0] data_in, data_out, host_d, tgt_wdata, rd_data, hold, q, wd;
  logic [15:0] dd;
  logic [15:0] chan_data = 16'h0000;
  int error_cnt = 0, checks = 0, wcnt = 0, n;
  initial forever #50 mclk = ~mclk;
  assign data_in = data_oe_n ? host_d : data_out;
  assign rd_data = {rd_addr, 14'h2b6d};
  dshp_host_port dut_u (
    .mclk(mclk),
    .rst_n(rst_n),
    .bus_style(bus_style),
    .cs_n(cs_n),
    .combined_data_strobe(combined_data_strobe),
    .rd_n(rd_n),
    .addr(addr),
    .data_in(data_in),
    .data_out(data_out),
    .data_oe_n(data_oe_n),
    .new_data_irq_n(new_data_irq_n),
    .tgt_wr(tgt_wr),
    .tgt_addr(tgt_addr),
    .tgt_wdata(tgt_wdata),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .chan_data(chan_data),
    .chan_synced(chan_synced),
    .new_data(new_data),
    .irq_len(irq_len)
  );
  dshp_host_model host_u (
    .mclk(mclk),
    .cs_n(cs_n),
    .combined_data_strobe(combined_data_strobe),
    .rd_n(rd_n),
    .addr(addr),
    .host_d(host_d),
    .data_in(data_in)
  );
  always @(posedge mclk) if (tgt_wr === 1'b1) begin
    wcnt <= wcnt + 1;
    wa <= tgt_addr;
    wd <= tgt_wdata;
  end
  function automatic logic [15:0] exp_rd(logic [1:0] k);
    case (k)
      2'h0: return hold;
      2'h3: return chan_synced ? chan_data : 16'h0000;
      default: return {k, 14'h2b6d};
    endcase
  endfunction : exp_rd
  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic summarize;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : summarize
  initial begin
    void'($urandom(32'hc140d274));
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      bus_style <= i[0];
      chan_synced <= i[1];
      chan_data <= 16'($urandom);
      hold = (i == 0) ? 16'hffff : 16'($urandom);
      repeat (4) @(posedge mclk);
      host_u.xfer(i[0], 1'b1, 1'b0, {i[2], 2'h0}, hold, q);
      a = 2'(1 + i % 3);
      n = wcnt;
      host_u.xfer(i[0], 1'b1, 1'b0, {~i[2], a}, 16'($urandom), q);
      chk("tgt_cnt", 16'(n + 1), 16'(wcnt));
      chk("tgt_addr", {14'h0, a}, {14'h0, wa});
      chk("tgt_wdata", hold, wd);
      dd = 16'($urandom);
      host_u.xfer(i[0], i[1], 1'b1, 3'h0, dd, q);
      chk("unsel_bus", dd, q);
      for (int k = 0; k < 4; k++) begin
        host_u.xfer(i[0], 1'b0, 1'b0, {i[3], 2'(k)},
          16'($urandom), q);
        chk("rd_data", exp_rd(2'(k)), q);
        #1 chk("oe_n", 16'h0001, {15'h0, data_oe_n});
      end
      chk("no_commit", 16'(n + 1), 16'(wcnt));
      irq_len <= (i < 2) ? 8'(i) : 8'($urandom_range(2, 20));
      @(posedge mclk);
      new_data <= 1'b1;
      n = 0;
      for (int k = 0; k < 300 && n == k; k++) begin
        @(posedge mclk);
        new_data <= 1'b0;
        #1 if (new_data_irq_n === 1'b0) n++;
      end
      chk("irq_len", (irq_len == 0) ? 16'h1 : 16'(irq_len), 16'(n));
      @(posedge mclk);
    end
    summarize();
  end
endmodule : tb_dual_style_host_bus_port
`default_nettype wire
